// ### hw/pmw_map.svh
// register map, field positions, reset values and timing counts
`ifndef PMW_MAP_SVH
`define PMW_MAP_SVH

`define PMW_IDX_PWRC      10'h080
`define PMW_IDX_STAT      10'h081
`define PMW_IDX_CLKCFG    10'h08f
`define PMW_IDX_IREN      10'h0a8
`define PMW_IDX_PRHI      10'h0b7
`define PMW_IDX_IPL       10'h0b8

`define PMW_PWRC_IDLE     0
`define PMW_PWRC_SLEEP    1
`define PMW_PWRC_COLD     4
`define PMW_CLK_LVL0      0
`define PMW_CLK_LVL1      1
`define PMW_CLK_WSEL      2
`define PMW_IREN_GATE     7
`define PMW_SRC_EXT0      3'h0
`define PMW_SRC_EXT1      3'h2

`define PMW_IREN_RST      8'h00
`define PMW_PRI_RST       8'h00
`define PMW_CLK_RST       3'h0
`define PMW_IREN_MASK     8'hdf
`define PMW_PRI_MASK      8'h5f
`define PMW_PERIPH_MASK   7'h5a
`define PMW_RESET_VECTOR  16'h0000

`define PMW_CLK_NS        4
`define PMW_STARTUP_NS    2000000
`define PMW_WAKE_NS       2000000
`define PMW_STARTUP_CYC   ((`PMW_STARTUP_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`define PMW_WAKE_CYC      ((`PMW_WAKE_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)

`endif

// ### hw/pmw_pkg.sv
// types shared by the power mode and wake-up controller
package pmw_pkg;

  typedef enum logic [2:0] {
    PMW_M_RUN,
    PMW_M_IDLE,
    PMW_M_PDOWN,
    PMW_M_WAKE_T,
    PMW_M_WAKE_P
  } pmw_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pmw_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pmw_apb_rsp_t;

  typedef struct packed {
    logic        core_rst_n;
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        comp_en;
    logic        osc_en;
    logic        flash_pwr_en;
    logic [15:0] start_addr;
  } pmw_pwr_t;

  typedef struct packed {
    logic       req;
    logic [2:0] src;
    logic [1:0] level;
  } pmw_irq_t;

  typedef struct packed {
    pmw_mode_t    mode;
    logic [18:0]  cnt;
    logic [7:0]   iren;
    logic [7:0]   prhi;
    logic [7:0]   ipl;
    logic         idle_req;
    logic         sleep_req;
    logic         cold;
    logic [2:0]   clkcfg;
    logic [1:0]   pin_q;
    logic [1:0]   ext_latch;
    logic         wake_pin;
    logic [3:0]   in_svc;
    pmw_apb_rsp_t apb;
    pmw_pwr_t     pwr;
    pmw_irq_t     irq;
  } pmw_state_t;

endpackage : pmw_pkg

// ### hw/pmw_ctrl.sv
// power mode, reset sequencing and wake-up controller with apb registers
//
// Notes on behaviour
// - internal reset clears all registers; cpu starts at address 0000; here the cold-start flag is kept through it
// - power-on, brown-out and external reset pin all force internal reset
// - after causes clear, count 2 ms before releasing internal reset
// - power-on detect reasserts internal reset at once, no delay
// - power-on reset sets the cold-start flag in power control
// - idle request stops cpu clock, all state and port levels held
// - in idle timers and serial keep clocks; comparator disabled
// - enabled interrupt or reset ends idle; service runs immediately
// - sleep request stops oscillator and powers flash off
// - ram kept through power-down; register contents not guaranteed
// - power-down left only by external reset, power-on or ext interrupt; here a brown-out detect also ends it
// - only enabled level-sensitive external pins wake from power-down
// - select zero: falling edge wakes, cpu clock gated for 2 ms
// - select one: falling edge wakes, cpu clock gated until pin rises
// - enable register bit layout, bit 5 unused, resets to zero
// - low-priority register per source, bits 7 and 5 unused, reset 0
// - high-priority register per source, same positions, reset zero
//
// The implementer's own choice: the APB register port.
`include "pmw_map.svh"
`timescale 1ns/100ps
`default_nettype none

module pmw_ctrl #(
  parameter int unsigned STARTUP_CYC = `PMW_STARTUP_CYC,
  parameter int unsigned WAKE_CYC    = `PMW_WAKE_CYC
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_por_det,
  input  wire logic                  i_brownout_det,
  input  wire logic                  i_ext_rst,
  input  wire logic                  i_ext_irq_zero_n,
  input  wire logic                  i_ext_irq_one_n,
  input  wire logic [6:0]            i_periph_irq,
  input  wire logic                  i_irq_ack,
  input  wire logic                  i_return_from_irq,
  input  wire pmw_pkg::pmw_apb_req_t i_apb,
  output var  pmw_pkg::pmw_apb_rsp_t o_apb,
  output var  pmw_pkg::pmw_pwr_t     o_pwr,
  output var  pmw_pkg::pmw_irq_t     o_irq
);
  import pmw_pkg::*;

  pmw_state_t s_q;
  pmw_state_t s_d;
  logic       rst_cause;
  logic [1:0] pins;
  logic [1:0] fall;
  logic [1:0] lvl;
  logic [1:0] ext_req;
  logic [1:0] wake_ok;
  logic [6:0] pend;
  logic       found;
  logic [2:0] best_src;
  logic [1:0] best_lvl;
  logic       wr;
  logic [9:0] idx;

  // highest level currently in service
  function automatic logic [1:0] top_level(input logic [3:0] svc);
    logic [1:0] t;
    t = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (svc[i]) begin
        t = 2'(i);
      end
    end
    return t;
  endfunction : top_level

  always_comb begin
    s_d       = s_q;
    rst_cause = i_por_det | i_brownout_det | i_ext_rst;
    pins      = {i_ext_irq_one_n, i_ext_irq_zero_n};
    fall      = s_q.pin_q & ~pins;
    lvl       = {s_q.clkcfg[`PMW_CLK_LVL1], s_q.clkcfg[`PMW_CLK_LVL0]};
    idx       = i_apb.paddr[11:2];
    wr        = i_apb.psel & i_apb.penable & s_q.apb.pready & i_apb.pwrite
                & s_q.pwr.core_rst_n;
    s_d.pin_q = pins;

    // level mode follows the pin; edge mode and wake-ups use the latch
    ext_req = (lvl & ~pins) | s_q.ext_latch;
    s_d.ext_latch = s_q.ext_latch;
    pend = ((i_periph_irq & `PMW_PERIPH_MASK)
            | {4'h0, ext_req[1], 1'b0, ext_req[0]})
           & s_q.iren[6:0] & {7{s_q.iren[`PMW_IREN_GATE]}};

    // strict compare keeps the lowest source index on equal level
    found    = 1'b0;
    best_src = 3'h0;
    best_lvl = 2'h0;
    for (int i = 0; i < 7; i++) begin
      if (pend[i] && (!found || {s_q.prhi[i], s_q.ipl[i]} > best_lvl)) begin
        found    = 1'b1;
        best_src = 3'(i);
        best_lvl = {s_q.prhi[i], s_q.ipl[i]};
      end
    end

    // in-service stack: return clears the top level, an ack pushes one
    if (i_return_from_irq) begin
      s_d.in_svc[top_level(s_q.in_svc)] = 1'b0;
    end
    if (i_irq_ack && s_q.irq.req) begin
      s_d.in_svc[s_q.irq.level] = 1'b1;
      if (s_q.irq.src == `PMW_SRC_EXT0) begin
        s_d.ext_latch[0] = 1'b0;
      end
      if (s_q.irq.src == `PMW_SRC_EXT1) begin
        s_d.ext_latch[1] = 1'b0;
      end
    end
    // a new edge wins over the ack clearing its latch
    s_d.ext_latch = s_d.ext_latch | (fall & ~lvl);

    s_d.irq.req   = found && s_q.mode == PMW_M_RUN && s_q.pwr.core_rst_n
                    && (s_q.in_svc == 4'h0
                        || best_lvl > top_level(s_q.in_svc));
    s_d.irq.src   = best_src;
    s_d.irq.level = best_lvl;

    // apb: one wait state, every access answered on the second edge
    s_d.apb.pready = i_apb.psel & i_apb.penable & ~s_q.apb.pready;
    if (s_d.apb.pready) begin
      s_d.apb.pslverr = 1'b0;
      unique case (idx)
        `PMW_IDX_PWRC: begin
          s_d.apb.prdata = 32'h0;
          s_d.apb.prdata[`PMW_PWRC_IDLE]  = s_q.idle_req;
          s_d.apb.prdata[`PMW_PWRC_SLEEP] = s_q.sleep_req;
          s_d.apb.prdata[`PMW_PWRC_COLD]  = s_q.cold;
        end
        `PMW_IDX_STAT:
          s_d.apb.prdata = {21'h0, s_q.in_svc, s_q.ext_latch,
                            s_q.wake_pin, s_q.pwr.core_rst_n, s_q.mode};
        `PMW_IDX_CLKCFG: s_d.apb.prdata = {29'h0, s_q.clkcfg};
        `PMW_IDX_IREN:   s_d.apb.prdata = {24'h0, s_q.iren};
        `PMW_IDX_PRHI:   s_d.apb.prdata = {24'h0, s_q.prhi};
        `PMW_IDX_IPL:    s_d.apb.prdata = {24'h0, s_q.ipl};
        default: begin
          s_d.apb.prdata  = 32'h0;
          s_d.apb.pslverr = 1'b1;
        end
      endcase
    end

    if (wr) begin
      unique case (idx)
        `PMW_IDX_PWRC: begin
          s_d.idle_req  = i_apb.pwdata[`PMW_PWRC_IDLE];
          s_d.sleep_req = i_apb.pwdata[`PMW_PWRC_SLEEP];
          s_d.cold      = i_apb.pwdata[`PMW_PWRC_COLD];
        end
        `PMW_IDX_CLKCFG: s_d.clkcfg = i_apb.pwdata[2:0];
        `PMW_IDX_IREN: s_d.iren = i_apb.pwdata[7:0] & `PMW_IREN_MASK;
        `PMW_IDX_PRHI: s_d.prhi = i_apb.pwdata[7:0] & `PMW_PRI_MASK;
        `PMW_IDX_IPL:  s_d.ipl  = i_apb.pwdata[7:0] & `PMW_PRI_MASK;
        default: ;
      endcase
    end

    // wake pins: enabled, gated on and set level-sensitive
    wake_ok = fall & lvl & {s_q.iren[2], s_q.iren[0]}
              & {2{s_q.iren[`PMW_IREN_GATE]}};

    if (s_q.pwr.core_rst_n) begin
      unique case (s_q.mode)
        PMW_M_RUN: begin
          if (s_q.sleep_req) begin
            s_d.mode = PMW_M_PDOWN;
          end else if (s_q.idle_req) begin
            s_d.mode = PMW_M_IDLE;
          end
        end
        PMW_M_IDLE: begin
          if (|pend) begin
            s_d.mode     = PMW_M_RUN;
            s_d.idle_req = 1'b0;
          end
        end
        PMW_M_PDOWN: begin
          // registers are not touched here, so ram and state survive
          if (|wake_ok) begin
            s_d.ext_latch = s_d.ext_latch | wake_ok;
            s_d.sleep_req = 1'b0;
            s_d.wake_pin  = ~wake_ok[0];
            s_d.cnt       = 19'h0;
            s_d.mode      = s_q.clkcfg[`PMW_CLK_WSEL] ? PMW_M_WAKE_P
                                                      : PMW_M_WAKE_T;
          end
        end
        PMW_M_WAKE_T: begin
          if (s_q.cnt == 19'(WAKE_CYC - 1)) begin
            s_d.cnt  = 19'h0;
            s_d.mode = PMW_M_RUN;
          end else begin
            s_d.cnt = s_q.cnt + 19'h1;
          end
        end
        PMW_M_WAKE_P: begin
          if (pins[s_q.wake_pin]) begin
            s_d.mode = PMW_M_RUN;
          end
        end
      endcase
    end else if (!rst_cause) begin
      if (s_q.cnt == 19'(STARTUP_CYC - 1)) begin
        s_d.cnt            = 19'h0;
        s_d.pwr.core_rst_n = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 19'h1;
      end
    end

    // any cause restarts the sequence at once; cold flag is kept
    if (rst_cause) begin
      s_d.mode           = PMW_M_RUN;
      s_d.cnt            = 19'h0;
      s_d.iren           = `PMW_IREN_RST;
      s_d.prhi           = `PMW_PRI_RST;
      s_d.ipl            = `PMW_PRI_RST;
      s_d.clkcfg         = `PMW_CLK_RST;
      s_d.idle_req       = 1'b0;
      s_d.sleep_req      = 1'b0;
      s_d.ext_latch      = 2'h0;
      s_d.in_svc         = 4'h0;
      s_d.irq.req        = 1'b0;
      s_d.pwr.core_rst_n = 1'b0;
    end
    if (i_por_det) begin
      s_d.cold = 1'b1;
    end

    s_d.pwr.cpu_clk_en    = s_d.mode == PMW_M_RUN;
    s_d.pwr.periph_clk_en = s_d.mode == PMW_M_RUN
                            || s_d.mode == PMW_M_IDLE;
    s_d.pwr.comp_en       = s_d.mode == PMW_M_RUN;
    s_d.pwr.osc_en        = s_d.mode != PMW_M_PDOWN;
    s_d.pwr.flash_pwr_en  = s_d.mode != PMW_M_PDOWN;
    s_d.pwr.start_addr    = `PMW_RESET_VECTOR;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_apb = s_q.apb;
  assign o_pwr = s_q.pwr;
  assign o_irq = s_q.irq;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_por_now;
    i_por_det |=> !o_pwr.core_rst_n && s_q.cnt == 19'h0;
  endproperty
  a_por_now: assert property (p_por_now)
    else $error("power-on detect did not force reset");

  property p_causes;
    (i_brownout_det || i_ext_rst) |=> !o_pwr.core_rst_n;
  endproperty
  a_causes: assert property (p_causes)
    else $error("brown-out or reset pin ignored");

  property p_release;
    $rose(o_pwr.core_rst_n) |->
      $past(s_q.cnt) == 19'(STARTUP_CYC - 1) && o_pwr.start_addr == 16'h0;
  endproperty
  a_release: assert property (p_release)
    else $error("reset released before start-up delay");

  property p_cold;
    i_por_det |=> s_q.cold;
  endproperty
  a_cold: assert property (p_cold)
    else $error("cold-start flag not set");

  property p_regs_reset;
    !o_pwr.core_rst_n |-> s_q.iren == 8'h0 && s_q.prhi == 8'h0
                          && s_q.ipl == 8'h0;
  endproperty
  a_regs_reset: assert property (p_regs_reset)
    else $error("interrupt registers not cleared in reset");

  property p_idle_entry;
    (s_q.mode == PMW_M_RUN && s_q.idle_req && !s_q.sleep_req
     && o_pwr.core_rst_n && !rst_cause)
      |=> s_q.mode == PMW_M_IDLE && !o_pwr.cpu_clk_en;
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("idle request did not stop cpu clock");

  property p_idle_clocks;
    s_q.mode == PMW_M_IDLE |-> o_pwr.periph_clk_en && !o_pwr.comp_en;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks)
    else $error("idle clocking wrong");

  property p_idle_exit;
    (s_q.mode == PMW_M_IDLE && |pend) |=> s_q.mode == PMW_M_RUN;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("enabled interrupt did not end idle");

  property p_pdown;
    s_q.mode == PMW_M_PDOWN |-> !o_pwr.osc_en && !o_pwr.flash_pwr_en;
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("oscillator or flash on in power-down");

  property p_pdown_stay;
    (s_q.mode == PMW_M_PDOWN && wake_ok == 2'h0 && !rst_cause)
      |=> s_q.mode == PMW_M_PDOWN;
  endproperty
  a_pdown_stay: assert property (p_pdown_stay)
    else $error("power-down left without a cause");

  property p_timed_wake;
    (s_q.mode == PMW_M_WAKE_T && s_q.cnt == 19'(WAKE_CYC - 1) && !rst_cause)
      |-> !o_pwr.cpu_clk_en ##1 s_q.mode == PMW_M_RUN && o_pwr.cpu_clk_en;
  endproperty
  a_timed_wake: assert property (p_timed_wake)
    else $error("timed wake-up did not end on count");

  property p_pin_wake;
    (s_q.mode == PMW_M_WAKE_P && !pins[s_q.wake_pin] && !rst_cause)
      |=> s_q.mode == PMW_M_WAKE_P && !o_pwr.cpu_clk_en;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("cpu clock released before pin rose");

  property p_gate;
    !s_q.iren[`PMW_IREN_GATE] |=> !o_irq.req;
  endproperty
  a_gate: assert property (p_gate)
    else $error("interrupt requested with global gate off");

  property p_preempt;
    o_irq.req |-> $past(s_q.in_svc) == 4'h0
                  || o_irq.level > top_level($past(s_q.in_svc));
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("request does not outrank level in service");

  c_release: cover property ($rose(o_pwr.core_rst_n));
  c_idle_exit: cover property (s_q.mode == PMW_M_IDLE
                               ##1 s_q.mode == PMW_M_RUN);
  c_timed: cover property (s_q.mode == PMW_M_WAKE_T
                           ##1 s_q.mode == PMW_M_RUN);
  c_pin: cover property (s_q.mode == PMW_M_WAKE_P
                         ##1 s_q.mode == PMW_M_RUN);

endmodule : pmw_ctrl

`default_nettype wire

// ### dv/pmw_pins.sv
// partner model: external interrupt sources on the two wake pins
`timescale 1ns/100ps
`default_nettype none

module pmw_pins (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic [1:0] i_hold,
  input  wire logic       i_timed,
  input  wire logic       i_cpu_run,
  output logic      [1:0] o_pin_n
);
  logic [1:0] low_q;

  // a timed wake must never see the pin rise before the cpu runs
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_q <= 2'h0;
    end else begin
      low_q <= i_hold | (low_q & {2{i_timed & ~i_cpu_run}});
    end
  end

  // a released pin is pulled up, so it idles high
  assign o_pin_n = ~low_q;
endmodule : pmw_pins

`default_nettype wire

// ### dv/pmw_ctrl_test.sv
// self-checking bench for the power mode and wake-up controller
`include "pmw_map.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  bad_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module pmw_ctrl_test;
  import pmw_pkg::*;
  localparam int unsigned STUP = 20;
  localparam int unsigned WAKE = 16;
  logic         clk;
  logic         rstn;
  logic         ack;
  logic         ret;
  logic         timed;
  logic [2:0]   cause;
  logic [6:0]   pirq;
  logic [1:0]   hold;
  logic [1:0]   pin_n;
  logic [31:0]  rdv;
  logic         err;
  pmw_apb_req_t apb_q;
  pmw_apb_rsp_t rsp;
  pmw_pwr_t     pwr;
  pmw_irq_t     irq;
  int           bad_count;
  int           comparisons;
  int           cyc;
  int           seed;
  int           n;
  int           m_en;
  int           m_h;
  int           m_l;
  int           m_p;

  pmw_ctrl #(.STARTUP_CYC(STUP), .WAKE_CYC(WAKE)) u_dut (
    .i_mclk(clk), .i_resetn(rstn), .i_por_det(cause[0]),
    .i_brownout_det(cause[1]), .i_ext_rst(cause[2]),
    .i_ext_irq_zero_n(pin_n[0]), .i_ext_irq_one_n(pin_n[1]),
    .i_periph_irq(pirq), .i_irq_ack(ack), .i_return_from_irq(ret),
    .i_apb(apb_q), .o_apb(rsp), .o_pwr(pwr), .o_irq(irq));

  pmw_pins u_pins (.i_mclk(clk), .i_resetn(rstn), .i_hold(hold),
    .i_timed(timed), .i_cpu_run(pwr.cpu_clk_en), .o_pin_n(pin_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic apb(input logic w, input logic [9:0] ix,
                     input logic [7:0] d);
    @(posedge clk);
    apb_q.psel <= 1'b1;
    apb_q.pwrite <= w;
    apb_q.paddr <= {ix, 2'b00};
    apb_q.pwdata <= {24'h0, d};
    @(posedge clk);
    apb_q.penable <= 1'b1;
    // no local limit: pready or the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rdv = rsp.prdata;
    err = rsp.pslverr;
    apb_q.psel <= 1'b0;
    apb_q.penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [9:0] ix, input logic [7:0] mk,
                       input logic [7:0] e, input string nm);
    apb(1'b0, ix, 8'h00);
    `CHK(nm, e, rdv[7:0] & mk)
  endtask : rdchk

  // the service routine masks every source before it returns
  task automatic ackret;
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    apb(1'b1, `PMW_IDX_IREN, 8'h00);
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
  endtask : ackret

  task automatic wait_core;
    n = 0;
    while (pwr.core_rst_n !== 1'b1 && n < STUP + 8) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_core

  task automatic wait_req;
    n = 0;
    while (irq.req !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_req

  // reference arbiter: highest level wins, ties go to the lowest index
  function automatic logic [5:0] pick(input int p, input int e,
                                      input int h, input int l);
    int b;
    int bl;
    int lv;
    b = -1;
    bl = 0;
    for (int s = 0; s < 7; s++) begin
      lv = 2 * h[s] + l[s];
      if (e[7] && e[s] && p[s] && (b < 0 || lv > bl)) begin
        b = s;
        bl = lv;
      end
    end
    return (b < 0) ? 6'h00 : {1'b1, b[2:0], bl[1:0]};
  endfunction : pick

  task automatic give_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rstn = 1'b0;
    cause = 3'h1;
    pirq = 7'h00;
    hold = 2'h0;
    timed = 1'b0;
    ack = 1'b0;
    ret = 1'b0;
    apb_q = '0;
    seed = 32'h7a15;
    bad_count = 0;
    comparisons = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    cause <= 3'h0;
    repeat (STUP - 2) @(posedge clk);
    #1 `CHK("core_rst_n early", 1'b0, pwr.core_rst_n)
    wait_core();
    `CHK("core_rst_n", 1'b1, pwr.core_rst_n)
    `CHK("start_addr", 16'h0000, pwr.start_addr)
    rdchk(`PMW_IDX_PWRC, 8'h10, 8'h10, "cold flag");
    rdchk(`PMW_IDX_IREN, 8'hff, 8'h00, "enable reset");
    rdchk(`PMW_IDX_PRHI, 8'hff, 8'h00, "prio high reset");
    rdchk(`PMW_IDX_IPL, 8'hff, 8'h00, "ipl reset");
    rdchk(`PMW_IDX_STAT, 8'h0f, 8'h08, "run status");
    apb(1'b0, 10'h001, 8'h00);
    `CHK("unmapped", 1'b1, err)
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, `PMW_IDX_PWRC, 8'h00);
      apb(1'b1, `PMW_IDX_IREN, 8'h81);
      @(posedge clk);
      cause <= 3'h1 << c;
      repeat (2) @(posedge clk);
      #1 `CHK("reset cause", 1'b0, pwr.core_rst_n)
      apb(1'b1, `PMW_IDX_IREN, 8'hff);
      rdchk(`PMW_IDX_IREN, 8'hff, 8'h00, "enable cleared");
      rdchk(`PMW_IDX_PWRC, 8'h10, (c == 0) ? 8'h10 : 8'h00, "cold");
      cause <= 3'h0;
      wait_core();
    end
    apb(1'b1, `PMW_IDX_IREN, 8'h82);
    apb(1'b1, `PMW_IDX_PWRC, 8'h01);
    repeat (2) @(posedge clk);
    #1 `CHK("idle cpu clk", 1'b0, pwr.cpu_clk_en)
    `CHK("idle periph", 1'b1, pwr.periph_clk_en)
    `CHK("idle comp", 1'b0, pwr.comp_en)
    rdchk(`PMW_IDX_STAT, 8'h0f, 8'h09, "idle status");
    pirq <= 7'h02;
    wait_req();
    `CHK("idle exit", 1'b1, pwr.cpu_clk_en)
    `CHK("idle irq", 6'h24, {irq.req, irq.src, irq.level})
    ackret();
    pirq <= 7'h00;
    for (int s = 0; s < 2; s++) begin
      // firmware leaves time after a start or a wake before sleeping
      repeat (1000) @(posedge clk);
      timed <= (s == 0);
      apb(1'b1, `PMW_IDX_CLKCFG, s ? 8'h06 : 8'h01);
      apb(1'b1, `PMW_IDX_IREN, s ? 8'h86 : 8'h83);
      apb(1'b1, `PMW_IDX_PWRC, 8'h02);
      pirq <= 7'h02;
      repeat (4) @(posedge clk);
      #1 `CHK("pdown osc", 1'b0, pwr.osc_en)
      `CHK("pdown flash", 1'b0, pwr.flash_pwr_en)
      @(posedge clk);
      pirq <= 7'h00;
      hold <= s ? 2'h2 : 2'h1;
      repeat (4) @(posedge clk);
      #1 `CHK("wake osc", 1'b1, pwr.osc_en)
      repeat (WAKE - 4) @(posedge clk);
      if (s) begin
        repeat (20) @(posedge clk);
      end
      #1 `CHK("wake gated", 1'b0, pwr.cpu_clk_en)
      @(posedge clk);
      hold <= 2'h0;
      n = 0;
      while (pwr.cpu_clk_en !== 1'b1 && n < 8) begin
        @(posedge clk);
        n++;
      end
      `CHK("wake run", 1'b1, pwr.cpu_clk_en)
      wait_req();
      `CHK("wake irq", s ? 6'h28 : 6'h20, {irq.req, irq.src, irq.level})
      ackret();
      rdchk(`PMW_IDX_CLKCFG, 8'h07, s ? 8'h06 : 8'h01, "clk kept");
    end
    // edge-sensitive ext0: a short low pulse leaves a latched request
    apb(1'b1, `PMW_IDX_CLKCFG, 8'h00);
    apb(1'b1, `PMW_IDX_IREN, 8'h81);
    hold <= 2'h1;
    @(posedge clk);
    hold <= 2'h0;
    wait_req();
    `CHK("edge irq", 6'h20, {irq.req, irq.src, irq.level})
    ackret();
    rdchk(`PMW_IDX_STAT, 8'h60, 8'h00, "edge latch");
    for (int i = 0; i < 40; i++) begin
      m_en = $random(seed);
      m_h = $random(seed);
      m_l = $random(seed);
      m_p = $random(seed);
      apb(1'b1, `PMW_IDX_IREN, m_en[7:0]);
      apb(1'b1, `PMW_IDX_PRHI, m_h[7:0]);
      apb(1'b1, `PMW_IDX_IPL, m_l[7:0]);
      pirq <= m_p[6:0];
      repeat (3) @(posedge clk);
      #1 `CHK("irq pick", pick(m_p & 'h5a, m_en, m_h & 'h5f, m_l & 'h5f),
        {irq.req, irq.src, irq.level})
      rdchk(`PMW_IDX_IREN, 8'hff, m_en[7:0] & 8'hdf, "enable");
      rdchk(`PMW_IDX_PRHI, 8'hff, m_h[7:0] & 8'h5f, "prio high");
      rdchk(`PMW_IDX_IPL, 8'hff, m_l[7:0] & 8'h5f, "ipl");
    end
    give_verdict();
  end
endmodule : pmw_ctrl_test

`default_nettype wire
